// >>> fdcs_pkg.sv
// types shared by the data-flash command sequencer
// assumes fdcs_regs.svh supplies all numeric constants
package fdcs_pkg;
  typedef enum logic [2:0] {
    FDCS_IDLE, FDCS_CHECK, FDCS_ERASE, FDCS_WRITE, FDCS_VERIFY, FDCS_DONE
  } fdcs_state_type;
endpackage

// >>> fdcs_regs.svh
// register offsets, field positions, reset values and command constants
// for the data-flash command sequencer; definitions only
`ifndef FDCS_REGS_SVH
`define FDCS_REGS_SVH
// apb byte offsets
`define FDCS_OFF_INDEX     12'h000
`define FDCS_OFF_PARAM     12'h004
`define FDCS_OFF_STATUS    12'h008
`define FDCS_OFF_CONFIG    12'h00c
`define FDCS_OFF_MARGIN    12'h010
// status bit positions
`define FDCS_ST_DONE       0
`define FDCS_ST_ACCESS_ERROR_FLAG     1
`define FDCS_ST_PROT       2
`define FDCS_ST_VERR       3
`define FDCS_ST_VUNC       4
// config bit positions
`define FDCS_CFG_SPECIAL   0
`define FDCS_CFG_ALLOW     1
`define FDCS_CFG_PROT_LO   4
// command codes
`define FDCS_CMD_MARGIN    8'h0e
`define FDCS_CMD_EVSECT    8'h10
`define FDCS_CMD_PROGRAM   8'h11
`define FDCS_CMD_ERASE     8'h12
// block selects (address bits 17:16)
`define FDCS_BLK_DATA      2'h0
`define FDCS_BLK_PROG      2'h3
// data-flash geometry: size and sector mask in bytes, sector size in words
`define FDCS_DF_SIZE       17'h01000
`define FDCS_SECTOR_MASK   16'hffc0
`define FDCS_SECTOR_WORDS  17'h00020
// index values
`define FDCS_IX_ONE        3'h1
`define FDCS_IX_TWO        3'h2
`define FDCS_IX_FIVE       3'h5
// margin level limit
`define FDCS_MARGIN_MAX    16'h0004
// time per array word step, ns, and derived cycles at 25 ns
`define FDCS_STEP_NS       100
`define FDCS_STEP_CYC      ((`FDCS_STEP_NS + 24) / 25)
`define FDCS_RST_CONFIG    32'h0000_0002
`endif

// >>> fdcs_sequencer.sv
// data-flash command sequencer: apb slave, launch checks, array model
// assumes a single pclk domain and a well-behaved apb master
//
// Design decisions made here: the address map and the APB slave port.
module fdcs_sequencer (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  // apb answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // status outputs
  output logic             cmd_complete_flag,
  output logic [2:0]       data_margin_level,
  output logic [2:0]       prog_margin_level
);
  `include "fdcs_regs.svh"

  // ******************************
  // register map
  // ******************************
  // index   : slot pointer, three bits, any value may be written
  // param   : the slot picked by the index, sixteen bits
  // status  : complete, access, protect, verify, uncorrectable, low bits up
  // config  : special mode, commands allowed, protect base in bits 15:4
  // margin  : program level above data level, three bits each
  // only the complete bit of status is writable, and only as a launch

  // ******************************
  // storage
  // ******************************
  // command slots and the array itself; neither is reset
  logic [15:0]  cmd_param_buffer [0:5];   // indexed command slots
  logic [15:0]  dflash_mem [0:2047];      // data-flash words
  logic [2:0]   cmd_buffer_index_r;       // current slot
  logic [31:0]  config_r;                 // mode, allow and protect bits
  // sticky status flags, cleared only by reset and by the next launch
  logic         access_error_flag_r;          // launch check failed
  logic         protect_violation_flag_r;     // target area protected
  logic         verify_error_flag_r;          // verify saw any error
  logic         verify_uncorrectable_flag_r;  // verify saw an uncorrectable error
  // sequencer state and the array walk shared by erase, program and verify
  fdcs_pkg::fdcs_state_type state_r;      // sequencer state
  // the pointer could wrap within the block; range checks keep it inside
  logic [10:0]  word_ptr_r;               // array word pointer
  logic [16:0]  words_left_r;             // words still to go
  logic [7:0]   step_cnt_r;               // per-word timing
  logic [2:0]   prog_slot_r;              // next program slot
  logic [10:0]  ver_start_r;              // verify start pointer
  logic [16:0]  ver_count_r;              // verify word count
  logic         ver_blank_r;              // verify expects erased

  // ******************************
  // decode helpers
  // ******************************
  // low byte address lies inside the data-flash block; the block
  // select is checked separately for each command
  function automatic logic addr_ok(input logic [15:0] lo);
    addr_ok = ({1'b0, lo} < `FDCS_DF_SIZE);
  endfunction

  // whether a word range stays inside the data-flash block
  // n is a word count, so it is doubled into bytes
  // summed at 18 bits so a huge count cannot wrap past the check
  function automatic logic range_ok(input logic [15:0] lo, input logic [16:0] n);
    range_ok = ({2'b0, lo} + {1'b0, n[15:0], 1'b0}) <= {1'b0, `FDCS_DF_SIZE};
  endfunction

  // protected when at or above the protect base
  // a base of zero leaves the whole block protected
  function automatic logic is_prot(input logic [15:0] lo);
    is_prot = lo[11:0] >= {config_r[15:`FDCS_CFG_PROT_LO]};
  endfunction

  // bus qualifiers: the access phase always carries pready here
  // a launch is a one written to the complete bit while idle
  wire logic acc_wr = psel && penable && pwrite;
  wire logic st_wr  = acc_wr && (paddr == `FDCS_OFF_STATUS);
  wire logic launch = st_wr && pready && pwdata[`FDCS_ST_DONE] && cmd_complete_flag;
  wire logic busy   = !cmd_complete_flag;
  // fields of the loaded command, read in the check cycle
  wire logic [7:0]  cmd  = cmd_param_buffer[0][15:8];
  wire logic [1:0]  blk  = cmd_param_buffer[0][1:0];
  wire logic [15:0] a_lo = cmd_param_buffer[1];
  wire logic        allow = config_r[`FDCS_CFG_ALLOW];
  // program word count: the launch index minus one
  wire logic [16:0] n_prog = {14'h0, cmd_buffer_index_r} - 17'h1;

  // ******************************
  // apb answer
  // ******************************
  // zero wait states; unmapped addresses answer with pslverr
  // the setup cycle is seen here and pready rises for the access phase
  // read data is captured at setup so it stands beside pready
  // an unmapped write is answered the same way and changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        case (paddr)
          `FDCS_OFF_INDEX:  prdata <= {29'h0, cmd_buffer_index_r};
          `FDCS_OFF_PARAM:  prdata <= (cmd_buffer_index_r <= `FDCS_IX_FIVE) ?
                                      {16'h0, cmd_param_buffer[cmd_buffer_index_r]} : 32'h0;
          `FDCS_OFF_STATUS: prdata <= {27'h0, verify_uncorrectable_flag_r,
                                      verify_error_flag_r, protect_violation_flag_r,
                                      access_error_flag_r, cmd_complete_flag};
          `FDCS_OFF_CONFIG: prdata <= config_r;
          `FDCS_OFF_MARGIN: prdata <= {26'h0, prog_margin_level, data_margin_level};
          default:          pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ******************************
  // software-written registers
  // ******************************
  // writes while busy are ignored so a running command keeps its slots
  // software must wait for complete anyway; the drop only guards the
  // sequencer against a careless write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_buffer_index_r <= 3'h0;
      config_r           <= `FDCS_RST_CONFIG;
    end else if (acc_wr && pready && !busy) begin
      if (paddr == `FDCS_OFF_INDEX) cmd_buffer_index_r <= pwdata[2:0];
      if (paddr == `FDCS_OFF_CONFIG) config_r <= pwdata;
    end
  end

  // slot writes go to the slot picked by the index
  // an index above five points at no slot and the write is lost
  always_ff @(posedge pclk) begin
    if (acc_wr && pready && !busy && paddr == `FDCS_OFF_PARAM &&
        cmd_buffer_index_r <= `FDCS_IX_FIVE) begin
      cmd_param_buffer[cmd_buffer_index_r] <= pwdata[15:0];
    end
  end

  // ******************************
  // sequencer
  // ******************************
  // launch clears errors, checks run in one cycle, array stepped per word
  // every launch fault lands in done straight from the check cycle, so
  // the array is never touched by a refused command
  // a verify pass reuses the pointer and count saved at check time
  // the complete flag is the only handshake software sees
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r                     <= fdcs_pkg::FDCS_IDLE;
      cmd_complete_flag           <= 1'b1;
      access_error_flag_r         <= 1'b0;
      protect_violation_flag_r    <= 1'b0;
      verify_error_flag_r         <= 1'b0;
      verify_uncorrectable_flag_r <= 1'b0;
      data_margin_level           <= 3'h0;
      prog_margin_level           <= 3'h0;
      word_ptr_r                  <= 11'h0;
      words_left_r                <= 17'h0;
      step_cnt_r                  <= 8'h0;
      prog_slot_r                 <= 3'h0;
      ver_start_r                 <= 11'h0;
      ver_count_r                 <= 17'h0;
      ver_blank_r                 <= 1'b0;
    end else begin
      case (state_r)
        // idle: wait for software to launch
        fdcs_pkg::FDCS_IDLE: begin
          // launch drops complete and clears every error flag
          if (launch) begin
            cmd_complete_flag           <= 1'b0;
            access_error_flag_r         <= 1'b0;
            protect_violation_flag_r    <= 1'b0;
            verify_error_flag_r         <= 1'b0;
            verify_uncorrectable_flag_r <= 1'b0;
            state_r                     <= fdcs_pkg::FDCS_CHECK;
          end
        end
        // check: one cycle of launch checks, then array work or done
        // pointer, timer and slot are loaded whatever the command
        fdcs_pkg::FDCS_CHECK: begin
          word_ptr_r  <= a_lo[11:1];
          step_cnt_r  <= 8'(`FDCS_STEP_CYC);
          prog_slot_r <= `FDCS_IX_TWO;
          state_r     <= fdcs_pkg::FDCS_DONE;
          case (cmd)
            // margin: no array work, the levels change in this cycle
            // a program-block level also covers data-flash reads
            `FDCS_CMD_MARGIN: begin
              if (cmd_buffer_index_r != `FDCS_IX_ONE || !config_r[`FDCS_CFG_SPECIAL] ||
                  (blk != `FDCS_BLK_DATA && blk != `FDCS_BLK_PROG) ||
                  cmd_param_buffer[1] > `FDCS_MARGIN_MAX) begin
                access_error_flag_r <= 1'b1;
              end else if (blk == `FDCS_BLK_PROG) begin
                prog_margin_level <= cmd_param_buffer[1][2:0];
                data_margin_level <= cmd_param_buffer[1][2:0];
              end else begin
                data_margin_level <= cmd_param_buffer[1][2:0];
              end
            end
            // erase-verify: read-only pass over the named range
            // a count of zero passes straight through to done
            `FDCS_CMD_EVSECT: begin
              if (cmd_buffer_index_r != `FDCS_IX_TWO || !allow ||
                  blk != `FDCS_BLK_DATA || !addr_ok(a_lo) || a_lo[0] ||
                  !range_ok(a_lo, {1'b0, cmd_param_buffer[2]})) begin
                access_error_flag_r <= 1'b1;
              end else begin
                ver_start_r <= a_lo[11:1];
                ver_count_r <= {1'b0, cmd_param_buffer[2]};
                words_left_r <= {1'b0, cmd_param_buffer[2]};
                ver_blank_r <= 1'b1;
                state_r     <= fdcs_pkg::FDCS_VERIFY;
              end
            end
            // program: the access checks come before protection
            // the index at launch fixes the word count
            `FDCS_CMD_PROGRAM: begin
              if (cmd_buffer_index_r < `FDCS_IX_TWO || cmd_buffer_index_r > `FDCS_IX_FIVE ||
                  !allow || blk != `FDCS_BLK_DATA || !addr_ok(a_lo) || a_lo[0] ||
                  !range_ok(a_lo, n_prog)) begin
                access_error_flag_r <= 1'b1;
              end else if (is_prot(a_lo)) begin
                protect_violation_flag_r <= 1'b1;
              end else begin
                words_left_r <= n_prog;
                ver_start_r  <= a_lo[11:1];
                ver_count_r  <= n_prog;
                ver_blank_r  <= 1'b0;
                state_r      <= fdcs_pkg::FDCS_WRITE;
              end
            end
            // sector erase: the whole sector, whatever word is named
            // protection is judged at the first byte of the sector
            `FDCS_CMD_ERASE: begin
              if (cmd_buffer_index_r != `FDCS_IX_ONE || !allow ||
                  blk != `FDCS_BLK_DATA || !addr_ok(a_lo) || a_lo[0]) begin
                access_error_flag_r <= 1'b1;
              end else if (is_prot(a_lo & `FDCS_SECTOR_MASK)) begin
                protect_violation_flag_r <= 1'b1;
              end else begin
                word_ptr_r   <= 11'((a_lo & `FDCS_SECTOR_MASK) >> 1);
                ver_start_r  <= 11'((a_lo & `FDCS_SECTOR_MASK) >> 1);
                words_left_r <= `FDCS_SECTOR_WORDS;
                ver_count_r  <= `FDCS_SECTOR_WORDS;
                ver_blank_r  <= 1'b1;
                state_r      <= fdcs_pkg::FDCS_ERASE;
              end
            end
            // unknown codes are refused like any other launch fault
            default: access_error_flag_r <= 1'b1;
          endcase
        end
        // erase and program share one stepping loop
        // the array write itself sits in its own process below
        fdcs_pkg::FDCS_ERASE, fdcs_pkg::FDCS_WRITE: begin
          // one word per step; then reload the pointer for the verify pass
          if (step_cnt_r > 8'h1) begin
            step_cnt_r <= step_cnt_r - 8'h1;
          end else begin
            step_cnt_r   <= 8'(`FDCS_STEP_CYC);
            word_ptr_r   <= word_ptr_r + 11'h1;
            prog_slot_r  <= prog_slot_r + 3'h1;
            words_left_r <= words_left_r - 17'h1;
            // last word: turn round into the verify pass
            if (words_left_r == 17'h1) begin
              word_ptr_r   <= ver_start_r;
              words_left_r <= ver_count_r;
              state_r      <= fdcs_pkg::FDCS_VERIFY;
            end
          end
        end
        // verify: compare each word, flags stay set until next launch
        fdcs_pkg::FDCS_VERIFY: begin
          // empty range, or last word already compared
          if (words_left_r == 17'h0) begin
            state_r <= fdcs_pkg::FDCS_DONE;
          end else if (step_cnt_r > 8'h1) begin
            step_cnt_r <= step_cnt_r - 8'h1;
          end else begin
            // a model array has no ecc, so mismatch is counted uncorrectable
            // slot of this word: counted back from the slot after the last written
            if (dflash_mem[word_ptr_r] != (ver_blank_r ? 16'hffff :
                cmd_param_buffer[3'(prog_slot_r - 3'(words_left_r))])) begin
              verify_error_flag_r         <= 1'b1;
              verify_uncorrectable_flag_r <= 1'b1;
            end
            step_cnt_r   <= 8'(`FDCS_STEP_CYC);
            word_ptr_r   <= word_ptr_r + 11'h1;
            words_left_r <= words_left_r - 17'h1;
          end
        end
        // done: one cycle to raise complete and return to idle
        fdcs_pkg::FDCS_DONE: begin
          cmd_complete_flag <= 1'b1;
          state_r           <= fdcs_pkg::FDCS_IDLE;
        end
        // unused state codes fall back to idle
        default: state_r <= fdcs_pkg::FDCS_IDLE;
      endcase
    end
  end

  // array writes: erase to all ones, program from slots two upward
  // the array has no reset: its contents after power-up are unknown
  // writes land on the last cycle of each word step
  always_ff @(posedge pclk) begin
    if (step_cnt_r == 8'h1 && state_r == fdcs_pkg::FDCS_ERASE) begin
      dflash_mem[word_ptr_r] <= 16'hffff;
    end else if (step_cnt_r == 8'h1 && state_r == fdcs_pkg::FDCS_WRITE) begin
      dflash_mem[word_ptr_r] <= cmd_param_buffer[prog_slot_r];
    end
  end
endmodule

// >>> fdcs_sequencer_bench.sv
// self-checking bench for the data-flash command sequencer
// assumes the sequencer and its bound checker are compiled first
`include "fdcs_regs.svh"
module fdcs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // signals and helpers
  // ************************************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        cmd_complete_flag;
  logic [2:0]  data_margin_level, prog_margin_level;
  int          n_mismatch, compares;
  fdcs_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_complete_flag(cmd_complete_flag),
    .data_margin_level(data_margin_level), .prog_margin_level(prog_margin_level));
  // 25 ns clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic hang();
    n_mismatch++;
    print_verdict();
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one apb transfer; pready sampled at the rising edge that ends the access
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 40) hang();
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask
  // load slots 0..3, set launch index, launch, wait, judge masked status
  task automatic cmd(input logic [63:0] s, input logic [2:0] ix, input logic [4:0] x,
                     input logic [4:0] m);
    int k = 0;
    for (int i = 0; i < 4; i++) begin
      wr(`FDCS_OFF_INDEX, 32'(i));
      wr(`FDCS_OFF_PARAM, {16'h0, s[63-16*i -: 16]});
    end
    wr(`FDCS_OFF_INDEX, {29'h0, ix});
    wr(`FDCS_OFF_STATUS, 32'h1);
    @(negedge pclk);
    while (cmd_complete_flag !== 1'b1) begin
      k++;
      if (k > 2000) hang();
      @(negedge pclk);
    end
    apb(1'b0, `FDCS_OFF_STATUS, 32'h0);
    chk("status", {27'h0, x & m}, {27'h0, q[4:0] & m});
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic margin_cmds();
    wr(`FDCS_OFF_CONFIG, 32'h2);
    cmd({16'h0e00, 16'h3, 32'h0}, 3'h1, 5'h03, 5'h1f);
    wr(`FDCS_OFF_CONFIG, 32'hfff3);
    for (int l = 0; l < 5; l++) begin
      cmd({16'h0e00, 16'(l), 32'h0}, 3'h1, 5'h01, 5'h1f);
      chk("data_margin", 32'(l), {29'h0, data_margin_level});
    end
    chk("prog_margin", 32'h0, {29'h0, prog_margin_level});
    cmd({16'h0e03, 16'h2, 32'h0}, 3'h1, 5'h01, 5'h1f);
    rd(`FDCS_OFF_MARGIN, 32'h12, "margins");
    cmd({16'h0e00, 16'h5, 32'h0}, 3'h1, 5'h03, 5'h1f);
    cmd({16'h0e00, 16'h1, 32'h0}, 3'h0, 5'h03, 5'h1f);
    cmd({16'h0e01, 16'h1, 32'h0}, 3'h1, 5'h03, 5'h1f);
    chk("data_margin", 32'h2, {29'h0, data_margin_level});
  endtask
  // erased words only are programmed; faults leave the array alone
  task automatic array_cmds();
    logic [63:0] f[12] = '{64'h1000_0101_0002_0000, 64'h1000_0100_0002_0000,
      64'h1000_0ffe_0002_0000, 64'h1100_0108_1111_2222, 64'h1100_0ffc_1111_2222,
      64'h1103_0108_1111_2222, 64'h1100_0108_1111_2222, 64'h1200_0101_0000_0000,
      64'h1200_0100_0000_0000, 64'h1300_0100_0000_0000, 64'h1000_0100_ffff_0000,
      64'h1200_1000_0000_0000};
    logic [2:0] fx[12] = '{3'h2, 3'h1, 3'h2, 3'h6, 3'h5, 3'h3, 3'h1, 3'h1, 3'h2, 3'h1, 3'h2,
      3'h1};
    cmd({16'h1200, 16'h0100, 32'h0}, 3'h1, 5'h01, 5'h1f);
    cmd({16'h1000, 16'h0100, 16'h4, 16'h0}, 3'h2, 5'h01, 5'h1f);
    cmd({16'h1100, 16'h0104, 32'ha5a5_5a5a}, 3'h3, 5'h01, 5'h1f);
    cmd({16'h1000, 16'h0104, 16'h2, 16'h0}, 3'h2, 5'h08, 5'h08);
    cmd({16'h1000, 16'h0108, 16'h2, 16'h0}, 3'h2, 5'h01, 5'h1f);
    for (int i = 0; i < 12; i++)
      cmd(f[i], fx[i], 5'h03, 5'h1f);
    cmd({16'h1000, 16'h0108, 16'h2, 16'h0}, 3'h2, 5'h01, 5'h1f);
  endtask
  task automatic protect_cmds();
    wr(`FDCS_OFF_CONFIG, 32'h3);
    cmd({16'h1100, 16'h0110, 32'h1234_0000}, 3'h2, 5'h05, 5'h1f);
    cmd({16'h1200, 16'h0110, 32'h0}, 3'h1, 5'h05, 5'h1f);
    wr(`FDCS_OFF_CONFIG, 32'h1);
    cmd({16'h1000, 16'h0110, 16'h1, 16'h0}, 3'h2, 5'h03, 5'h1f);
    wr(`FDCS_OFF_CONFIG, 32'hfff3);
    cmd({16'h1000, 16'h0110, 16'h1, 16'h0}, 3'h2, 5'h01, 5'h1f);
    rd(`FDCS_OFF_INDEX, 32'h2, "index");
    rd(`FDCS_OFF_PARAM, 32'h1, "slot_two");
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FDCS_OFF_STATUS, 32'h1, "status_rst");
    rd(`FDCS_OFF_CONFIG, `FDCS_RST_CONFIG, "config_rst");
    rd(`FDCS_OFF_MARGIN, 32'h0, "margin_rst");
    margin_cmds();
    array_cmds();
    protect_cmds();
    print_verdict();
  end
endmodule

// >>> fdcs_sequencer_checker.sv
// port-level concurrent checks for the data-flash command sequencer
// assumes one pclk domain and the offsets and codes of fdcs_regs.svh
`include "fdcs_regs.svh"
module fdcs_sequencer_checker (
  // apb clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb request
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // status
  input wire logic        cmd_complete_flag,
  input wire logic [2:0]  data_margin_level,
  input wire logic [2:0]  prog_margin_level
);
  // ************************************************************
  // mirror of what software loaded
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] idx_r;   // slot index as written
  logic [7:0] code_r;  // command code in slot zero
  // writes while busy are dropped by the block, so mirror that
  wire wr     = psel & penable & pready & pwrite & cmd_complete_flag;
  wire launch = wr & (paddr == `FDCS_OFF_STATUS) & pwdata[0];
  // index outside the command's allowed set, or any other code, margin included
  wire quick  = (code_r == `FDCS_CMD_EVSECT) ? (idx_r != 3'h2) :
                (code_r == `FDCS_CMD_PROGRAM) ? (idx_r < 3'h2 || idx_r > 3'h5) :
                (code_r == `FDCS_CMD_ERASE) ? (idx_r != 3'h1) : 1'b1;
  // index follows every accepted index write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      idx_r <= 3'h0;
    else if (wr && paddr == `FDCS_OFF_INDEX)
      idx_r <= pwdata[2:0];
  // code only taken from slot zero
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      code_r <= 8'h00;
    else if (wr && paddr == `FDCS_OFF_PARAM && idx_r == 3'h0)
      code_r <= pwdata[15:8];
  // busy for one cycle, then complete within two more
  sequence s_short_run;
    ##1 !cmd_complete_flag ##[1:2] cmd_complete_flag;
  endsequence
  // ************************************************************
  // assertions
  // ************************************************************
  a_launch_busy: assert property (launch |=> !cmd_complete_flag)
    else $error("complete flag high after launch");
  a_margin_done: assert property (launch && code_r == `FDCS_CMD_MARGIN |-> s_short_run)
    else $error("margin command timing wrong");
  a_fault_done: assert property (launch && quick && code_r != `FDCS_CMD_MARGIN |-> s_short_run)
    else $error("faulty launch not completed at once");
  a_data_margin: assert property ($changed(data_margin_level) |-> !$past(cmd_complete_flag))
    else $error("data margin changed while idle");
  a_prog_margin: assert property ($changed(prog_margin_level) |-> !$past(cmd_complete_flag))
    else $error("program margin changed while idle");
  a_margin_range: assert property (data_margin_level <= 3'h4 && prog_margin_level <= 3'h4)
    else $error("margin level out of range");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_err_unmapped: assert property (pslverr |-> pready && !(paddr inside {`FDCS_OFF_INDEX,
    `FDCS_OFF_PARAM, `FDCS_OFF_STATUS, `FDCS_OFF_CONFIG, `FDCS_OFF_MARGIN}))
    else $error("slave error on mapped address");
endmodule
bind fdcs_sequencer fdcs_sequencer_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmd_complete_flag(cmd_complete_flag), .data_margin_level(data_margin_level),
  .prog_margin_level(prog_margin_level));
